/* hw/pcpm_pkg.sv */
// package: register map, field layout and carriers of the port c pin mux
package pcpm_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] pcpm_upper_direction_off       = 12'h000;
    localparam logic [11:0] pcpm_lower_direction_off       = 12'h004;
    localparam logic [11:0] pcpm_upper_function_select_off = 12'h008;
    localparam logic [11:0] pcpm_lower_function_one_off    = 12'h00c;

    // ------------------------------------------------------------------
    // writable bits and values after reset
    // ------------------------------------------------------------------
    localparam logic [15:0] pcpm_upper_direction_mask      = 16'h001f;
    localparam logic [15:0] pcpm_lower_direction_mask      = 16'hffff;
    localparam logic [15:0] pcpm_upper_function_mask       = 16'h0155;
    localparam logic [15:0] pcpm_lower_function_one_mask   = 16'h5500;
    localparam logic [15:0] pcpm_direction_reset           = 16'h0000;
    localparam logic [15:0] pcpm_function_reset            = 16'h0000;

    // ------------------------------------------------------------------
    // function bit positions
    // ------------------------------------------------------------------
    localparam int pcpm_pin20_function_bit = 8;
    localparam int pcpm_pin19_function_bit = 6;
    localparam int pcpm_pin18_function_bit = 4;
    localparam int pcpm_pin17_function_bit = 2;
    localparam int pcpm_pin16_function_bit = 0;
    localparam int pcpm_pin15_function_bit = 14;
    localparam int pcpm_pin14_function_bit = 12;
    localparam int pcpm_pin13_function_bit = 10;
    localparam int pcpm_pin12_function_bit = 8;

    localparam int pcpm_pins     = 21;
    localparam int pcpm_low_pins = 16;

    // ------------------------------------------------------------------
    // carriers to and from the ethernet controller
    // ------------------------------------------------------------------
    typedef struct packed {
        logic wake_on_lan_out;
        logic ethernet_external_out;
        logic mdc;
        logic mdio_out;
        logic mdio_oe;
        logic tx_en;
    } pcpm_eth_out_type;

    typedef struct packed {
        logic link_status_in;
        logic mdio_in;
        logic crs;
        logic col;
        logic tx_clk;
    } pcpm_eth_in_type;

endpackage

/* hw/pcpm_port_c_mux.sv */
// port c direction and function select: apb registers and per-pin mux
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module pcpm_port_c_mux (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [20:0]               port_out_data,
    output logic      [20:0]               port_in_data,
    input  wire logic [20:0]               pad_in,
    output logic      [20:0]               pad_out,
    output logic      [20:0]               pad_oe,
    input  wire pcpm_pkg::pcpm_eth_out_type eth_out,
    output pcpm_pkg::pcpm_eth_in_type      eth_in
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [15:0] upper_direction_r;
    logic [15:0] lower_direction_r;
    logic [15:0] upper_function_r;
    logic [15:0] lower_function_one_r;
    logic [15:0] upper_direction_nxt;
    logic [15:0] lower_direction_nxt;
    logic [15:0] upper_function_nxt;
    logic [15:0] lower_function_one_nxt;

    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire access_w  = psel & penable;
    wire finish_w  = access_w & pready_r;
    wire hit_udir  = (paddr == pcpm_pkg::pcpm_upper_direction_off);
    wire hit_ldir  = (paddr == pcpm_pkg::pcpm_lower_direction_off);
    wire hit_ufun  = (paddr == pcpm_pkg::pcpm_upper_function_select_off);
    wire hit_lfun  = (paddr == pcpm_pkg::pcpm_lower_function_one_off);
    wire mapped_w  = hit_udir | hit_ldir | hit_ufun | hit_lfun;
    wire wr_w      = finish_w & pwrite;
    // the first access cycle prepares the answer given in the next one
    wire first_w      = access_w & ~pready_r;
    wire rd_capture_w = first_w & ~pwrite;

    // ------------------------------------------------------------------
    // per-register write strobes and writable bits of the write data
    // ------------------------------------------------------------------
    wire        wr_udir_w = wr_w & hit_udir;
    wire        wr_ldir_w = wr_w & hit_ldir;
    wire        wr_ufun_w = wr_w & hit_ufun;
    wire        wr_lfun_w = wr_w & hit_lfun;
    wire [15:0] wdata_w   = pwdata[15:0];
    wire [15:0] udir_wdata_w;
    wire [15:0] ldir_wdata_w;
    wire [15:0] ufun_wdata_w;
    wire [15:0] lfun_wdata_w;

    // reserved positions are masked on write so they always read zero
    assign udir_wdata_w = wdata_w & pcpm_pkg::pcpm_upper_direction_mask;
    assign ldir_wdata_w = wdata_w & pcpm_pkg::pcpm_lower_direction_mask;
    assign ufun_wdata_w = wdata_w & pcpm_pkg::pcpm_upper_function_mask;
    assign lfun_wdata_w = wdata_w & pcpm_pkg::pcpm_lower_function_one_mask;

    // ------------------------------------------------------------------
    // next register values
    // ------------------------------------------------------------------
    assign upper_direction_nxt    = wr_udir_w ? udir_wdata_w :
                                    upper_direction_r;
    assign lower_direction_nxt    = wr_ldir_w ? ldir_wdata_w :
                                    lower_direction_r;
    assign upper_function_nxt     = wr_ufun_w ? ufun_wdata_w :
                                    upper_function_r;
    assign lower_function_one_nxt = wr_lfun_w ? lfun_wdata_w :
                                    lower_function_one_r;

    // ------------------------------------------------------------------
    // read-back values, reserved positions held at zero
    // ------------------------------------------------------------------
    wire [15:0] udir_view_w;
    wire [15:0] ldir_view_w;
    wire [15:0] ufun_view_w;
    wire [15:0] lfun_view_w;

    assign udir_view_w = upper_direction_r &
                         pcpm_pkg::pcpm_upper_direction_mask;
    assign ldir_view_w = lower_direction_r &
                         pcpm_pkg::pcpm_lower_direction_mask;
    assign ufun_view_w = upper_function_r &
                         pcpm_pkg::pcpm_upper_function_mask;
    assign lfun_view_w = lower_function_one_r &
                         pcpm_pkg::pcpm_lower_function_one_mask;

    wire [15:0] read_sel_w =
        hit_udir ? udir_view_w :
        hit_ldir ? ldir_view_w :
        hit_ufun ? ufun_view_w :
        hit_lfun ? lfun_view_w : 16'h0000;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_direction_r <= pcpm_pkg::pcpm_direction_reset;
        end else begin
            upper_direction_r <= upper_direction_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_direction_r <= pcpm_pkg::pcpm_direction_reset;
        end else begin
            lower_direction_r <= lower_direction_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upper_function_r <= pcpm_pkg::pcpm_function_reset;
        end else begin
            upper_function_r <= upper_function_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lower_function_one_r <= pcpm_pkg::pcpm_function_reset;
        end else begin
            lower_function_one_r <= lower_function_one_nxt;
        end
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= first_w;
        end
    end

    // unmapped addresses answer with an error, together with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= first_w & ~mapped_w;
        end
    end

    // read data stands only while pready does, zero otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_capture_w) begin
            prdata_r <= {16'h0000, read_sel_w};
        end else if (finish_w) begin
            prdata_r <= 32'h0000_0000;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------------
    // per-pin function select and peripheral drive
    // ------------------------------------------------------------------
    logic [20:0] func_sel_w;
    logic [20:0] periph_out_w;
    logic [20:0] periph_oe_w;
    logic [20:0] direction_w;

    assign direction_w = {upper_direction_r[4:0], lower_direction_r};

    // ------------------------------------------------------------------
    // named function select bits, one per multiplexed pin
    // ------------------------------------------------------------------
    logic pin20_function_bit;
    logic pin19_function_bit;
    logic pin18_function_bit;
    logic pin17_function_bit;
    logic pin16_function_bit;
    logic pin15_function_bit;
    logic pin14_function_bit;
    logic pin13_function_bit;
    logic pin12_function_bit;

    assign pin20_function_bit =
        upper_function_r[pcpm_pkg::pcpm_pin20_function_bit];
    assign pin19_function_bit =
        upper_function_r[pcpm_pkg::pcpm_pin19_function_bit];
    assign pin18_function_bit =
        upper_function_r[pcpm_pkg::pcpm_pin18_function_bit];
    assign pin17_function_bit =
        upper_function_r[pcpm_pkg::pcpm_pin17_function_bit];
    assign pin16_function_bit =
        upper_function_r[pcpm_pkg::pcpm_pin16_function_bit];
    assign pin15_function_bit =
        lower_function_one_r[pcpm_pkg::pcpm_pin15_function_bit];
    assign pin14_function_bit =
        lower_function_one_r[pcpm_pkg::pcpm_pin14_function_bit];
    assign pin13_function_bit =
        lower_function_one_r[pcpm_pkg::pcpm_pin13_function_bit];
    assign pin12_function_bit =
        lower_function_one_r[pcpm_pkg::pcpm_pin12_function_bit];

    assign func_sel_w = {
        pin20_function_bit,
        pin19_function_bit,
        pin18_function_bit,
        pin17_function_bit,
        pin16_function_bit,
        pin15_function_bit,
        pin14_function_bit,
        pin13_function_bit,
        pin12_function_bit,
        12'h000
    };

    // input functions keep the pad undriven
    assign periph_out_w = {
        eth_out.wake_on_lan_out,
        eth_out.ethernet_external_out,
        1'b0,
        eth_out.mdc,
        eth_out.mdio_out,
        3'h0,
        eth_out.tx_en,
        12'h000
    };
    assign periph_oe_w = {
        1'b1,
        1'b1,
        1'b0,
        1'b1,
        eth_out.mdio_oe,
        3'h0,
        1'b1,
        12'h000
    };

    // ------------------------------------------------------------------
    // pad input filter: three stages, change once last two agree
    // ------------------------------------------------------------------
    logic [20:0] sync1_r;
    logic [20:0] sync2_r;
    logic [20:0] sync3_r;
    logic [20:0] pad_clean_r;
    logic [20:0] pad_out_r;
    logic [20:0] pad_oe_r;
    logic [20:0] port_in_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 21'h000000;
        end else begin
            sync1_r <= pad_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync2_r <= 21'h000000;
        end else begin
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync3_r <= 21'h000000;
        end else begin
            sync3_r <= sync2_r;
        end
    end

    genvar g;
    generate
        for (g = 0; g < pcpm_pkg::pcpm_pins; g++) begin : pin_gen
            wire agree_w     = (sync2_r[g] == sync3_r[g]);
            wire port_mode_w = ~func_sel_w[g];
            // port mode takes the direction bit, otherwise the peripheral
            wire oe_w  = port_mode_w ? direction_w[g] :
                         periph_oe_w[g];
            wire out_w = port_mode_w ? port_out_data[g] :
                         periph_out_w[g];

            // the clean level moves only once two stages agree
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pad_clean_r[g] <= 1'b0;
                end else if (agree_w) begin
                    pad_clean_r[g] <= sync3_r[g];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pad_oe_r[g]  <= 1'b0;
                    pad_out_r[g] <= 1'b0;
                end else begin
                    pad_oe_r[g]  <= oe_w;
                    pad_out_r[g] <= out_w & oe_w;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    port_in_r[g] <= 1'b0;
                end else begin
                    port_in_r[g] <= pad_clean_r[g];
                end
            end
        end
    endgenerate

    assign pad_out      = pad_out_r;
    assign pad_oe       = pad_oe_r;
    assign port_in_data = port_in_r;

    // ------------------------------------------------------------------
    // inputs routed to the ethernet controller
    // ------------------------------------------------------------------
    pcpm_pkg::pcpm_eth_in_type eth_in_nxt;
    pcpm_pkg::pcpm_eth_in_type eth_in_r;

    assign eth_in_nxt.link_status_in = func_sel_w[18] & pad_clean_r[18];
    assign eth_in_nxt.mdio_in        = func_sel_w[16] & pad_clean_r[16];
    assign eth_in_nxt.crs            = func_sel_w[15] & pad_clean_r[15];
    assign eth_in_nxt.col            = func_sel_w[14] & pad_clean_r[14];
    assign eth_in_nxt.tx_clk         = func_sel_w[13] & pad_clean_r[13];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eth_in_r <= '0;
        end else begin
            eth_in_r <= eth_in_nxt;
        end
    end

    assign eth_in = eth_in_r;

endmodule

/* verification/pcpm_port_c_mux_properties.sv */
// checker: apb handshake and pin output relations of the port c pin mux
module pcpm_port_c_mux_properties (
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic [20:0]               pad_out,
    input wire logic [20:0]               pad_oe,
    input wire pcpm_pkg::pcpm_eth_in_type eth_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_ready_delay: assert property (
        psel && !penable |-> ##2 pready) else $error("ready not on time");
    chk_ready_pulse: assert property (
        pready |=> !pready) else $error("ready longer than a cycle");
    chk_ready_cause: assert property (
        pready |-> $past(psel && !penable, 2)) else $error("ready unasked");
    chk_upper_half_zero: assert property (
        pready |-> prdata[31:16] == 16'h0000) else $error("upper half set");
    chk_rdata_idle: assert property (
        !pready |-> prdata == 32'h0) else $error("read data outside answer");
    chk_err_with_ready: assert property (
        pslverr |-> pready) else $error("error without ready");
    chk_out_gated: assert property (
        (pad_out & ~pad_oe) == 21'h0) else $error("undriven pin shows data");
    chk_reset_inputs: assert property (
        $rose(presetn) |-> pad_oe == 21'h0 && eth_in == '0)
        else $error("pins not inputs after reset");
    chk_oe_hold: assert property (
        !psel [*3] |-> $stable(pad_oe[15:0]))
        else $error("direction moved without a write");

    cover property (pready && !pslverr);
    cover property (pslverr);
    cover property (pad_oe[20] && pad_oe[17]);
endmodule

bind pcpm_port_c_mux pcpm_port_c_mux_properties u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_out(pad_out), .pad_oe(pad_oe), .eth_in(eth_in));

/* verification/pcpm_eth_model.sv */
// partner: ethernet controller outputs and package pin levels
module pcpm_eth_model (
    input  wire logic [20:0]           pad_out,
    input  wire logic [20:0]           pad_oe,
    input  wire logic [20:0]           ext_level,
    input  wire logic                  pclk,
    output logic      [20:0]           pad_in,
    output pcpm_pkg::pcpm_eth_out_type eth_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cnt_r = 6'h00;
    // controller outputs take a new pattern every cycle
    always_ff @(posedge pclk) begin
        cnt_r <= cnt_r + 6'h25;
    end
    assign eth_out = pcpm_pkg::pcpm_eth_out_type'(cnt_r);
    // the driving party wins; undriven pins see the far side
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

/* verification/pcpm_port_c_mux_tb.sv */
// self-checking bench of the port c pin mux
module pcpm_port_c_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [20:0] port_out_data = 21'h0, ext_level = 21'h0;
    logic [20:0] port_q, port_in_data, pad_in, pad_out, pad_oe;
    pcpm_pkg::pcpm_eth_out_type eth_out, eth_q;
    pcpm_pkg::pcpm_eth_in_type  eth_in;
    logic [15:0] mdl [4] = '{default: 16'h0};
    logic [15:0] msk [4];
    int          num_errors = 0;
    int          n_compared = 0;
    int          seed = 10286;

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        port_out_data <= 21'($random(seed));
        eth_q <= eth_out;
        port_q <= port_out_data;
    end

    pcpm_port_c_mux u_pcpm_port_c_mux (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_out_data(port_out_data),
        .port_in_data(port_in_data), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .eth_out(eth_out), .eth_in(eth_in));
    pcpm_eth_model u_pcpm_eth_model (.pad_out(pad_out), .pad_oe(pad_oe),
        .ext_level(ext_level), .pclk(pclk), .pad_in(pad_in),
        .eth_out(eth_out));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            give_verdict();
        end
    endtask

    function automatic logic [20:0] exp_oe();
        logic [20:0] o;
        o = {mdl[0][4:0], mdl[1]};
        o[12] = o[12] | mdl[3][8];
        o[13] = o[13] & ~mdl[3][10];
        o[14] = o[14] & ~mdl[3][12];
        o[15] = o[15] & ~mdl[3][14];
        o[16] = mdl[2][0] ? eth_q.mdio_oe : o[16];
        o[17] = o[17] | mdl[2][2];
        o[18] = o[18] & ~mdl[2][4];
        o[19] = o[19] | mdl[2][6];
        o[20] = o[20] | mdl[2][8];
        return o;
    endfunction

    function automatic logic [20:0] exp_out();
        logic [20:0] o;
        o = port_q;
        if (mdl[3][8]) o[12] = eth_q.tx_en;
        if (mdl[2][0]) o[16] = eth_q.mdio_out;
        if (mdl[2][2]) o[17] = eth_q.mdc;
        if (mdl[2][6]) o[19] = eth_q.ethernet_external_out;
        if (mdl[2][8]) o[20] = eth_q.wake_on_lan_out;
        return o & exp_oe();
    endfunction

    task automatic wr_chk(input int i, input logic [31:0] v);
        logic [31:0] rd;
        logic        err;
        logic [4:0]  ei;
        logic [20:0] m;
        logic [4:0]  em;
        @(posedge pclk);
        ext_level <= 21'($random(seed));
        apb(1'b1, 12'(i * 4), v, rd, err);
        mdl[i] = v[15:0] & msk[i];
        apb(1'b0, 12'(i * 4), 32'h0, rd, err);
        check(rd, {16'h0, mdl[i]});
        check({31'h0, err}, 32'h0);
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        ei = {mdl[2][4] & ext_level[18], 1'b0, mdl[3][14] & ext_level[15],
              mdl[3][12] & ext_level[14], mdl[3][10] & ext_level[13]};
        m = ~exp_oe() & (mdl[2][0] ? 21'h1effff : 21'h1fffff);
        em = mdl[2][0] ? 5'h17 : 5'h1f;
        check(32'(pad_oe), 32'(exp_oe()));
        check(32'(pad_out), 32'(exp_out()));
        check(32'(eth_in & em), 32'(ei));
        check(32'(port_in_data & m), 32'(ext_level & m));
    endtask

    initial begin
        logic [31:0] rd, v;
        logic        err;
        int          i;
        msk = '{pcpm_pkg::pcpm_upper_direction_mask,
                pcpm_pkg::pcpm_lower_direction_mask,
                pcpm_pkg::pcpm_upper_function_mask,
                pcpm_pkg::pcpm_lower_function_one_mask};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0, rd, err);
            check(rd, 32'h0);
        end
        check(32'(pad_oe), 32'h0);
        for (i = 0; i < 4; i++) begin
            wr_chk(i, 32'hffffffff);
        end
        repeat (40) begin
            i = $unsigned($random(seed)) % 4;
            v = $random(seed);
            wr_chk(i, {16'h0, v[15:0] & msk[i]});
        end
        apb(1'b1, 12'h010, 32'h0000ffff, rd, err);
        check({31'h0, err}, 32'h1);
        apb(1'b0, 12'h010, 32'h0, rd, err);
        check(rd, 32'h0);
        check({31'h0, err}, 32'h1);
        give_verdict();
    end
endmodule
